// ### inc/bdu_pkg.sv
// shared constants of the breakpoint debug unit
package bdu_pkg;
   localparam int          NUM_BP        = 4;
   localparam int          TF_BIT        = 8;
   // register selectors of the move port
   localparam logic [2:0]  SEL_STATUS    = 3'h6;
   localparam logic [2:0]  SEL_CTRL      = 3'h7;
   // control register fields
   localparam int          CTRL_TYPE_LSB = 16;
   localparam int          CTRL_LEN_LSB  = 18;
   localparam int          CTRL_BP_STEP  = 4;
   localparam int          CTRL_GUARD    = 13;
   localparam int          CTRL_RSV_ONE  = 10;
   localparam logic [31:0] CTRL_WR_MASK  = 32'hffff_20ff;
   localparam logic [31:0] CTRL_ONES     = 32'h0000_0400;
   localparam logic [31:0] CTRL_RESET    = 32'h0000_0400;
   localparam logic [31:0] ADDR_RESET    = 32'h0000_0000;
   // status register fields
   localparam int          STAT_GUARD    = 13;
   localparam int          STAT_STEP     = 14;
   localparam logic [31:0] STAT_RESET    = 32'h0000_0000;
   // access type and length codes
   localparam logic [1:0]  TYPE_EXEC     = 2'h0;
   localparam logic [1:0]  TYPE_WRITE    = 2'h1;
   localparam logic [1:0]  TYPE_RDWR     = 2'h3;
   localparam logic [1:0]  LEN_1         = 2'h0;
   localparam logic [1:0]  LEN_2         = 2'h1;
   localparam logic [1:0]  LEN_4         = 2'h3;

   // bytes of a dword covered by an aligned region
   function automatic logic [3:0] byte_mask(input logic [1:0] a, input logic [1:0] len);
      logic [3:0] m;
      m = 4'h0;
      case (len)
         LEN_1:   m = 4'h1 << a;
         LEN_2:   m = a[1] ? 4'hc : 4'h3;
         LEN_4:   m = 4'hf;
         default: m = 4'h0;
      endcase
      return m;
   endfunction
endpackage

// ### inc/bdu_core_if.sv
// signals between the top, the comparators and the status capture
interface bdu_core_if;
   logic [31:0] bp_addr [4];
   logic [31:0] ctrl;
   logic        fetch_valid;
   logic [31:0] fetch_addr;
   logic        data_valid;
   logic        data_write;
   logic [31:0] data_addr;
   logic [1:0]  data_size;
   logic [3:0]  code_hit;
   logic [3:0]  data_hit;
   logic        take;
   logic        step;
   logic        guard;
   logic        sw_clear;
   logic [31:0] sw_data;
   logic [31:0] status;

   modport top (output bp_addr, ctrl, fetch_valid, fetch_addr, data_valid, data_write,
                output data_addr, data_size, take, step, guard, sw_clear, sw_data,
                input code_hit, data_hit, status);
   modport cmp (input bp_addr, ctrl, fetch_valid, fetch_addr, data_valid, data_write,
                input data_addr, data_size, output code_hit, data_hit);
   modport stat (input take, step, guard, sw_clear, sw_data, code_hit, data_hit,
                 output status);
endinterface

// ### core/bdu_match.sv
// address, type and length comparators of the four breakpoints
module bdu_match (
   // comparator side of the core bus
   bdu_core_if.cmp bus
);
   always_comb
   begin
      logic [1:0] kind;
      logic [1:0] len;
      logic [3:0] bp_m;
      logic       same_f;
      logic       same_d;
      kind = 2'h0;
      len = 2'h0;
      bp_m = 4'h0;
      same_f = 1'b0;
      same_d = 1'b0;
      for (int n = 0; n < bdu_pkg::NUM_BP; n++)
      begin
         kind = bus.ctrl[bdu_pkg::CTRL_TYPE_LSB + bdu_pkg::CTRL_BP_STEP * n +: 2];
         len = bus.ctrl[bdu_pkg::CTRL_LEN_LSB + bdu_pkg::CTRL_BP_STEP * n +: 2];
         // aligned region of the breakpoint against the touched bytes
         bp_m = bdu_pkg::byte_mask(bus.bp_addr[n][1:0], len);
         same_f = (bus.fetch_addr[31:2] == bus.bp_addr[n][31:2])
                  && |(bp_m & bdu_pkg::byte_mask(bus.fetch_addr[1:0], bdu_pkg::LEN_1));
         same_d = (bus.data_addr[31:2] == bus.bp_addr[n][31:2])
                  && |(bp_m & bdu_pkg::byte_mask(bus.data_addr[1:0], bus.data_size));
         // type decode; the unused code never matches
         bus.code_hit[n] = bus.fetch_valid && same_f
                           && (kind == bdu_pkg::TYPE_EXEC);
         bus.data_hit[n] = bus.data_valid && same_d
                           && ((kind == bdu_pkg::TYPE_RDWR)
                               || (kind == bdu_pkg::TYPE_WRITE && bus.data_write));
      end
   end
endmodule

// ### core/bdu_status.sv
// sticky capture of the debug status bits
module bdu_status (
   // clock, reset and enable
   input  wire logic clk_in,
   input  wire logic rst_in,
   input  wire logic ce_in,
   // status side of the core bus
   bdu_core_if.stat  bus
);
   logic [31:0] status_q;
   logic [31:0] status_d;

   always_comb
   begin
      status_d = status_q;
      // software clears by writing zeros; hardware never clears
      if (bus.sw_clear)
         status_d = status_q & bus.sw_data;
      if (bus.take)
      begin
         // every matching breakpoint, enabled or not; set wins over clear
         status_d[bdu_pkg::NUM_BP-1:0] = status_d[bdu_pkg::NUM_BP-1:0]
                                         | bus.code_hit | bus.data_hit;
         status_d[bdu_pkg::STAT_STEP] = status_d[bdu_pkg::STAT_STEP] | bus.step;
         status_d[bdu_pkg::STAT_GUARD] = status_d[bdu_pkg::STAT_GUARD] | bus.guard;
      end
   end

   always_ff @(posedge clk_in)
   begin
      if (rst_in)
         status_q <= bdu_pkg::STAT_RESET;
      else if (ce_in)
         status_q <= status_d;
   end

   assign bus.status = status_q;

   default clocking cb @(posedge clk_in);
   endclocking
   default disable iff (rst_in);

   status_sticky_a: assert property (
      ce_in && !bus.sw_clear |=> (status_q & $past(status_q)) == $past(status_q))
      else $error("status bit dropped without software clear");
   hit_flag_a: assert property (
      ce_in && bus.take && (bus.code_hit[0] || bus.data_hit[0]) |=> status_q[0])
      else $error("matched breakpoint not flagged");
   disabled_flag_a: assert property (
      ce_in && bus.take && bus.code_hit[2] |=> status_q[2])
      else $error("disabled breakpoint match not flagged");
   step_flag_a: assert property (
      ce_in && bus.take && bus.step |=> status_q[bdu_pkg::STAT_STEP])
      else $error("single step cause not flagged");
endmodule

// ### core/bdu_top.sv
// breakpoint debug unit: register moves, enables and debug exceptions
//
// Overview of operation
// - four address registers hold the linear addresses of four breakpoints.
// - an enabled breakpoint hit by a matching access raises a debug exception.
// - the watched region is one, two or four bytes at the stored address.
// - register moves are only allowed at privilege zero; real mode counts as zero.
// - control holds local enable, access type and length for every breakpoint.
// - an execution breakpoint is taken before the instruction has any effect.
// - control layout: length/type pairs high, guard bit 13, bit 10 one, enables low.
// - writes to the status register can only clear its bits; it records the exception's conditions.
// - hardware never clears status; software clears it itself.
// - the one-byte trap instruction raises a code breakpoint exception.
// - with the single-step flag set, every instruction ends in a debug exception.
// - type 00 execute, 01 write, 11 read or write, 10 unused.
// - length 00 one byte, 01 two bytes, 11 four bytes, 10 unused.
// - every debug exception clears the access guard bit.
// - status flags each breakpoint whose conditions matched in an exception cycle, even when disabled.
module bdu_top (
   // clock, reset, enable
   input  wire logic        clk_in,
   input  wire logic        rst_in,
   input  wire logic        ce_in,
   // register move port
   input  wire logic        mov_valid_in,
   input  wire logic        mov_write_in,
   input  wire logic [2:0]  mov_sel_in,
   input  wire logic [31:0] mov_wdata_in,
   input  wire logic [1:0]  priv_level_in,
   input  wire logic        real_mode_in,
   output logic      [31:0] mov_rdata_out,
   output logic             mov_done_out,
   output logic             mov_fault_out,
   // instruction fetch
   input  wire logic        fetch_valid_in,
   input  wire logic [31:0] fetch_addr_in,
   // data access
   input  wire logic        data_valid_in,
   input  wire logic        data_write_in,
   input  wire logic [31:0] data_addr_in,
   input  wire logic [1:0]  data_size_in,
   // instruction retirement
   input  wire logic        retire_valid_in,
   input  wire logic        retire_trap_in,
   input  wire logic [31:0] processor_flags_in,
   // exceptions to the core
   output logic             code_hold_out,
   output logic             debug_exc_out,
   output logic             breakpoint_trap_out
);
   bdu_core_if core_if ();

   logic [31:0] breakpoint_address_regs_q [4];
   logic [31:0] breakpoint_address_regs_d [4];
   logic [31:0] breakpoint_control_q;
   logic [31:0] breakpoint_control_d;
   logic [31:0] rdata_q;
   logic [31:0] rdata_d;
   logic        done_q;
   logic        done_d;
   logic        fault_q;
   logic        fault_d;
   logic        exc_q;
   logic        exc_d;
   logic        trap_q;
   logic        trap_d;

   logic [3:0]  bp_enable;
   logic        priv_ok;
   logic        access_guard;
   logic        reg_op;
   logic        guard_trip;
   logic        code_brk;
   logic        data_brk;
   logic        single_step;
   logic        take;

   bdu_match u_match (
      .bus (core_if.cmp)
   );

   bdu_status u_status (
      .clk_in (clk_in),
      .rst_in (rst_in),
      .ce_in  (ce_in),
      .bus    (core_if.stat)
   );

   // streams toward the comparators
   assign core_if.bp_addr = breakpoint_address_regs_q;
   assign core_if.ctrl = breakpoint_control_q;
   assign core_if.fetch_valid = fetch_valid_in;
   assign core_if.fetch_addr = fetch_addr_in;
   assign core_if.data_valid = data_valid_in;
   assign core_if.data_write = data_write_in;
   assign core_if.data_addr = data_addr_in;
   assign core_if.data_size = data_size_in;

   // local or global enable per breakpoint
   always_comb
   begin
      for (int n = 0; n < bdu_pkg::NUM_BP; n++)
         bp_enable[n] = |breakpoint_control_q[2*n +: 2];
   end

   assign access_guard = breakpoint_control_q[bdu_pkg::CTRL_GUARD];
   assign priv_ok = real_mode_in || (priv_level_in == 2'h0);
   // a guarded move is refused and turns into a debug exception
   assign guard_trip = mov_valid_in && priv_ok && access_guard;
   assign reg_op = mov_valid_in && priv_ok && !access_guard;

   assign code_brk = |(core_if.code_hit & bp_enable);
   assign data_brk = |(core_if.data_hit & bp_enable);
   assign single_step = retire_valid_in && processor_flags_in[bdu_pkg::TF_BIT];
   assign take = ce_in && (code_brk || data_brk || single_step || guard_trip);

   // status capture sees every event of the exception cycle
   assign core_if.take = take;
   assign core_if.step = single_step;
   assign core_if.guard = guard_trip;
   assign core_if.sw_clear = reg_op && mov_write_in && (mov_sel_in == bdu_pkg::SEL_STATUS);
   assign core_if.sw_data = mov_wdata_in;

   // instruction is held in the same cycle so it never executes
   assign code_hold_out = fetch_valid_in && code_brk;

   always_comb
   begin
      breakpoint_address_regs_d = breakpoint_address_regs_q;
      breakpoint_control_d = breakpoint_control_q;
      rdata_d = rdata_q;
      done_d = reg_op;
      fault_d = mov_valid_in && !priv_ok;
      exc_d = take;
      trap_d = retire_valid_in && retire_trap_in;
      if (reg_op && mov_write_in)
      begin
         if (!mov_sel_in[2])
            breakpoint_address_regs_d[mov_sel_in[1:0]] = mov_wdata_in;
         else if (mov_sel_in == bdu_pkg::SEL_CTRL)
            breakpoint_control_d = (mov_wdata_in & bdu_pkg::CTRL_WR_MASK)
                                   | bdu_pkg::CTRL_ONES;
      end
      if (reg_op && !mov_write_in)
      begin
         if (!mov_sel_in[2])
            rdata_d = breakpoint_address_regs_q[mov_sel_in[1:0]];
         else if (mov_sel_in == bdu_pkg::SEL_STATUS)
            rdata_d = core_if.status;
         else if (mov_sel_in == bdu_pkg::SEL_CTRL)
            rdata_d = (breakpoint_control_q & bdu_pkg::CTRL_WR_MASK)
                      | bdu_pkg::CTRL_ONES;
         else
            rdata_d = 32'h0000_0000;
      end
      // exception's clear of the guard bit wins over a same-cycle control write
      if (take)
         breakpoint_control_d[bdu_pkg::CTRL_GUARD] = 1'b0;
   end

   always_ff @(posedge clk_in)
   begin
      if (rst_in)
      begin
         for (int n = 0; n < bdu_pkg::NUM_BP; n++)
            breakpoint_address_regs_q[n] <= bdu_pkg::ADDR_RESET;
         breakpoint_control_q <= bdu_pkg::CTRL_RESET;
         rdata_q <= 32'h0000_0000;
         done_q <= 1'b0;
         fault_q <= 1'b0;
         exc_q <= 1'b0;
         trap_q <= 1'b0;
      end
      else if (ce_in)
      begin
         breakpoint_address_regs_q <= breakpoint_address_regs_d;
         breakpoint_control_q <= breakpoint_control_d;
         rdata_q <= rdata_d;
         done_q <= done_d;
         fault_q <= fault_d;
         exc_q <= exc_d;
         trap_q <= trap_d;
      end
   end

   assign mov_rdata_out = rdata_q;
   assign mov_done_out = done_q;
   assign mov_fault_out = fault_q;
   assign debug_exc_out = exc_q;
   assign breakpoint_trap_out = trap_q;

   default clocking cb @(posedge clk_in);
   endclocking
   default disable iff (rst_in);

   sequence exec_bp0_seen;
      ce_in && fetch_valid_in && bp_enable[0]
      && breakpoint_control_q[17:16] == bdu_pkg::TYPE_EXEC
      && breakpoint_control_q[19:18] != 2'h2
      && fetch_addr_in == breakpoint_address_regs_q[0];
   endsequence

   sequence write_bp1_seen;
      ce_in && data_valid_in && data_write_in && bp_enable[1]
      && breakpoint_control_q[21:20] == bdu_pkg::TYPE_WRITE
      && breakpoint_control_q[23:22] != 2'h2 && data_size_in != 2'h2
      && data_addr_in == breakpoint_address_regs_q[1];
   endsequence

   sequence step_seen;
      ce_in && retire_valid_in && processor_flags_in[bdu_pkg::TF_BIT];
   endsequence

   sequence any_exc;
      ce_in && (code_brk || data_brk || single_step || guard_trip);
   endsequence

   code_hold_a: assert property (exec_bp0_seen |-> code_hold_out ##1 debug_exc_out)
      else $error("execution breakpoint not held");
   data_break_a: assert property (write_bp1_seen |=> debug_exc_out)
      else $error("write breakpoint missed");
   single_step_a: assert property (step_seen |=> debug_exc_out)
      else $error("single step exception missed");
   guard_clear_a: assert property (any_exc |=> !access_guard)
      else $error("guard bit survived exception");
   trap_inst_a: assert property (
      ce_in && retire_valid_in && retire_trap_in |=> breakpoint_trap_out)
      else $error("trap instruction ignored");
   priv_fault_a: assert property (
      ce_in && mov_valid_in && !priv_ok |=> mov_fault_out && !mov_done_out)
      else $error("privileged move not refused");

   property ctrl_read_p;
      ce_in && reg_op && !mov_write_in && mov_sel_in == bdu_pkg::SEL_CTRL
      |=> mov_rdata_out[10] && mov_rdata_out[15:14] == 2'h0 && mov_done_out;
   endproperty
   ctrl_layout_a: assert property (ctrl_read_p) else $error("control read layout wrong");

   property addr_store_p;
      ce_in && reg_op && mov_write_in && mov_sel_in == 3'h2 && !take
      ##1 ce_in && reg_op && !mov_write_in && mov_sel_in == 3'h2
      |=> mov_rdata_out == $past(mov_wdata_in, 2);
   endproperty
   addr_store_a: assert property (addr_store_p) else $error("address register lost write");

   // data-side matches and refusals, watched on breakpoint one
   sequence data_bp1_seen;
      ce_in && data_valid_in;
   endsequence

   sequence exc_free;
      ce_in && !(code_brk || data_brk || single_step || guard_trip);
   endsequence

   type_unused_a: assert property (
      data_bp1_seen ##0 breakpoint_control_q[21:20] == 2'h2 |-> !core_if.data_hit[1])
      else $error("unused access type matched");

   len_unused_a: assert property (
      data_bp1_seen ##0 breakpoint_control_q[23:22] == 2'h2 |-> !core_if.data_hit[1])
      else $error("unused length matched");

   exec_no_data_a: assert property (
      data_bp1_seen ##0 breakpoint_control_q[21:20] == bdu_pkg::TYPE_EXEC
      |-> !core_if.data_hit[1])
      else $error("execution breakpoint matched data");

   write_only_a: assert property (
      data_bp1_seen ##0 (!data_write_in && breakpoint_control_q[21:20] == bdu_pkg::TYPE_WRITE)
      |-> !core_if.data_hit[1])
      else $error("write breakpoint matched a read");

   rdwr_hit_a: assert property (
      data_bp1_seen ##0 (breakpoint_control_q[21:20] == bdu_pkg::TYPE_RDWR
      && breakpoint_control_q[23:22] == bdu_pkg::LEN_1 && data_size_in == bdu_pkg::LEN_1
      && data_addr_in == breakpoint_address_regs_q[1]) |-> core_if.data_hit[1])
      else $error("read or write breakpoint missed");

   other_dword_a: assert property (
      data_bp1_seen ##0 data_addr_in[31:2] != breakpoint_address_regs_q[1][31:2]
      |-> !core_if.data_hit[1])
      else $error("access outside region matched");

   quiet_a: assert property (exc_free |=> !debug_exc_out)
      else $error("debug exception without cause");

   guard_move_a: assert property (
      ce_in && guard_trip |=> debug_exc_out && !mov_done_out && !mov_fault_out)
      else $error("guarded move not turned into exception");

   done_pulse_a: assert property (
      ce_in && !mov_valid_in |=> !mov_done_out && !mov_fault_out)
      else $error("move answer without request");

   status_read_a: assert property (
      ce_in && reg_op && !mov_write_in && mov_sel_in == bdu_pkg::SEL_STATUS
      |=> mov_rdata_out == $past(core_if.status))
      else $error("status read wrong");

   status_ro_a: assert property (
      ce_in && core_if.sw_clear && !take
      |=> (core_if.status & ~$past(core_if.status)) == 32'h0000_0000)
      else $error("status write set a bit");

   ctrl_write_a: assert property (
      ce_in && reg_op && mov_write_in && mov_sel_in == bdu_pkg::SEL_CTRL
      |=> breakpoint_control_q[10] && breakpoint_control_q[15:14] == 2'h0
      && breakpoint_control_q[12:11] == 2'h0 && breakpoint_control_q[9:8] == 2'h0)
      else $error("control write broke reserved bits");

   trap_quiet_a: assert property (
      exc_free ##0 (retire_valid_in && retire_trap_in && !mov_valid_in)
      |=> core_if.status == $past(core_if.status) && !debug_exc_out)
      else $error("trap instruction touched status");
endmodule

// ### dv/bdu_core_model.sv
// core-side model: issues fetch, data and retire cycles to the unit
module bdu_core_model (
   // clock
   input  wire logic        clk_in,
   // from the unit
   input  wire logic        code_hold_in,
   input  wire logic        debug_exc_in,
   input  wire logic        breakpoint_trap_in,
   // to the unit
   output logic             fetch_valid_out,
   output logic      [31:0] fetch_addr_out,
   output logic             data_valid_out,
   output logic             data_write_out,
   output logic      [31:0] data_addr_out,
   output logic      [1:0]  data_size_out,
   output logic             retire_valid_out,
   output logic             retire_trap_out,
   output logic      [31:0] processor_flags_out
);
   timeunit 1ns;
   timeprecision 1ps;

   initial
   begin
      fetch_valid_out = 1'b0;
      fetch_addr_out = 32'h0;
      data_valid_out = 1'b0;
      data_write_out = 1'b0;
      data_addr_out = 32'h0;
      data_size_out = 2'h0;
      retire_valid_out = 1'b0;
      retire_trap_out = 1'b0;
      processor_flags_out = 32'h0;
   end

   // kind 0 fetch, 1 data, 2 retire; one cycle, then the answer a cycle later
   task automatic cycle(input int kind, input logic wr, input logic [31:0] a,
                        input logic [1:0] sz, input logic [31:0] fl, input logic tr,
                        output logic hold, output logic exc, output logic trp);
      @(posedge clk_in);
      fetch_valid_out <= (kind == 0);
      data_valid_out <= (kind == 1);
      data_write_out <= wr;
      fetch_addr_out <= a;
      data_addr_out <= a;
      data_size_out <= sz;
      retire_valid_out <= (kind == 2);
      retire_trap_out <= tr;
      processor_flags_out <= fl;
      // a held fetch is never executed, so no retire follows it
      #1 hold = code_hold_in;
      @(posedge clk_in);
      fetch_valid_out <= 1'b0;
      data_valid_out <= 1'b0;
      retire_valid_out <= 1'b0;
      // address, write and trap lines show the inverse of their last value; size and flags hold
      fetch_addr_out <= ~a;
      data_addr_out <= ~a;
      data_write_out <= ~wr;
      retire_trap_out <= ~tr;
      #1 exc = debug_exc_in;
      trp = breakpoint_trap_in;
   endtask
endmodule

// ### dv/breakpoint_debug_unit_tb.sv
// self-checking bench of the breakpoint debug unit
module breakpoint_debug_unit_tb;
   timeunit 1ns;
   timeprecision 1ps;

   logic        clk_in = 1'b0;
   logic        rst_in = 1'b1;
   logic        mov_valid = 1'b0;
   logic        mov_write = 1'b0;
   logic [2:0]  mov_sel = 3'h0;
   logic [31:0] mov_wdata = 32'h0;
   logic [1:0]  priv = 2'h0;
   logic        real_mode = 1'b0;
   logic        ce = 1'b1;
   logic [31:0] mov_rdata, fa, da, fl, rd;
   logic        mov_done, mov_fault, code_hold, debug_exc, trap;
   logic        fv, dv, dw, rv, rt, h, e, t, dn, ft, ex;
   logic [1:0]  ds;
   int          n_mismatch = 0;
   int          checks = 0;
   // fields {type, len, write, size, hit, addr low nibble}
   logic [11:0] tab [11] = '{12'h494, 12'h404, 12'hc14, 12'h084, 12'hbe4, 12'hd15,
                             12'hd06, 12'hf17, 12'he04, 12'hc74, 12'hc22};

   always #12.5 clk_in = ~clk_in;

   bdu_top i_dut (.clk_in(clk_in), .rst_in(rst_in), .ce_in(ce),
      .mov_valid_in(mov_valid), .mov_write_in(mov_write), .mov_sel_in(mov_sel),
      .mov_wdata_in(mov_wdata), .priv_level_in(priv), .real_mode_in(real_mode),
      .mov_rdata_out(mov_rdata), .mov_done_out(mov_done), .mov_fault_out(mov_fault),
      .fetch_valid_in(fv), .fetch_addr_in(fa), .data_valid_in(dv), .data_write_in(dw),
      .data_addr_in(da), .data_size_in(ds), .retire_valid_in(rv), .retire_trap_in(rt),
      .processor_flags_in(fl), .code_hold_out(code_hold), .debug_exc_out(debug_exc),
      .breakpoint_trap_out(trap));

   bdu_core_model i_core (.clk_in(clk_in), .code_hold_in(code_hold),
      .debug_exc_in(debug_exc), .breakpoint_trap_in(trap), .fetch_valid_out(fv),
      .fetch_addr_out(fa), .data_valid_out(dv), .data_write_out(dw),
      .data_addr_out(da), .data_size_out(ds), .retire_valid_out(rv),
      .retire_trap_out(rt), .processor_flags_out(fl));

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic mov(input logic wr, input logic [2:0] sel, input logic [31:0] d);
      @(posedge clk_in);
      mov_valid <= 1'b1;
      mov_write <= wr;
      mov_sel <= sel;
      mov_wdata <= d;
      @(posedge clk_in);
      mov_valid <= 1'b0;
      mov_wdata <= ~d;
      #1 rd = mov_rdata;
      dn = mov_done;
      ft = mov_fault;
      ex = debug_exc;
   endtask

   task automatic rdchk(input logic [2:0] sel, input logic [31:0] exp);
      mov(1'b0, sel, 32'h0);
      chk(dn, 32'h1);
      chk(rd, exp);
   endtask

   task automatic t_reset;
      for (int i = 0; i < 4; i++)
         rdchk(3'(i), 32'h0);
      rdchk(3'h7, 32'h0000_0400);
      rdchk(3'h6, 32'h0);
      rdchk(3'h4, 32'h0);
      for (int i = 0; i < 4; i++)
         mov(1'b1, 3'(i), 32'h1111_0000 * (i + 1));
      for (int i = 0; i < 4; i++)
         rdchk(3'(i), 32'h1111_0000 * (i + 1));
      mov(1'b1, 3'h6, 32'hffff_ffff);
      rdchk(3'h6, 32'h0);
      $display("test reset done");
   endtask

   task automatic t_priv;
      priv <= 2'h3;
      mov(1'b1, 3'h0, 32'h0000_0abc);
      chk(ft, 32'h1);
      chk(dn, 32'h0);
      real_mode <= 1'b1;
      rdchk(3'h0, 32'h1111_0000);
      real_mode <= 1'b0;
      priv <= 2'h0;
      $display("test privilege done");
   endtask

   task automatic t_ctrl;
      mov(1'b1, 3'h7, 32'hffff_04ff);
      rdchk(3'h7, 32'hffff_04ff);
      mov(1'b1, 3'h7, 32'h0000_0400);
      $display("test control done");
   endtask

   task automatic t_exec;
      mov(1'b1, 3'h0, 32'h0000_1000);
      mov(1'b1, 3'h2, 32'h0000_1000);
      mov(1'b1, 3'h7, 32'h0000_0401);
      i_core.cycle(0, 1'b0, 32'h0000_1001, 2'h0, 32'h0, 1'b0, h, e, t);
      chk(h, 32'h0);
      chk(e, 32'h0);
      i_core.cycle(0, 1'b0, 32'h0000_1000, 2'h0, 32'h0, 1'b0, h, e, t);
      chk(h, 32'h1);
      chk(e, 32'h1);
      rdchk(3'h6, 32'h5);
      rdchk(3'h6, 32'h5);
      mov(1'b1, 3'h6, 32'h0);
      rdchk(3'h6, 32'h0);
      $display("test execute done");
   endtask

   task automatic t_data;
      mov(1'b1, 3'h1, 32'h0000_2004);
      foreach (tab[i])
      begin
         mov(1'b1, 3'h7, 32'h0000_0404 | (32'(tab[i][11:10]) << 20)
                                       | (32'(tab[i][9:8]) << 22));
         i_core.cycle(1, tab[i][7], 32'h0000_2000 + 32'(tab[i][3:0]), tab[i][6:5],
                      32'h0, 1'b0, h, e, t);
         chk(e, 32'(tab[i][4]));
      end
      mov(1'b1, 3'h6, 32'h0);
      $display("test data done");
   endtask

   task automatic t_step;
      i_core.cycle(2, 1'b0, 32'h0, 2'h0, 32'h0000_0100, 1'b0, h, e, t);
      chk(e, 32'h1);
      rdchk(3'h6, 32'h0000_4000);
      mov(1'b1, 3'h6, 32'h0);
      i_core.cycle(2, 1'b0, 32'h0, 2'h0, 32'h0, 1'b1, h, e, t);
      chk(t, 32'h1);
      chk(e, 32'h0);
      rdchk(3'h6, 32'h0);
      $display("test step done");
   endtask

   task automatic t_guard;
      mov(1'b1, 3'h7, 32'h0000_2400);
      mov(1'b0, 3'h0, 32'h0);
      chk(dn, 32'h0);
      chk(ex, 32'h1);
      rdchk(3'h6, 32'h0000_2000);
      rdchk(3'h7, 32'h0000_0400);
      mov(1'b1, 3'h6, 32'h0);
      mov(1'b1, 3'h7, 32'h0000_2400);
      i_core.cycle(2, 1'b0, 32'h0, 2'h0, 32'h0000_0100, 1'b0, h, e, t);
      rdchk(3'h7, 32'h0000_0400);
      $display("test guard done");
   endtask

   task automatic t_burst;
      @(posedge clk_in);
      mov_valid <= 1'b1;
      mov_write <= 1'b1;
      mov_sel <= 3'h2;
      mov_wdata <= 32'h0000_5a5a;
      // read of the same register right behind the write
      @(posedge clk_in);
      mov_write <= 1'b0;
      @(posedge clk_in);
      mov_write <= 1'b1;
      mov_wdata <= 32'h0000_0000;
      ce <= 1'b0;
      #1 chk(mov_rdata, 32'h0000_5a5a);
      chk(mov_done, 32'h1);
      // frozen: the pending write is not taken and done holds
      repeat (2) @(posedge clk_in);
      #1 chk(mov_done, 32'h1);
      @(posedge clk_in);
      ce <= 1'b1;
      mov_valid <= 1'b0;
      rdchk(3'h2, 32'h0000_5a5a);
      $display("test burst done");
   endtask

   task automatic end_sim;
      $display("checks %0d mismatches %0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   initial
   begin
      repeat (3) @(posedge clk_in);
      rst_in <= 1'b0;
      t_reset();
      t_priv();
      t_ctrl();
      t_exec();
      t_data();
      t_step();
      t_guard();
      t_burst();
      end_sim();
   end

   // whole run needs well under 400 cycles
   initial
   begin
      #100000;
      n_mismatch++;
      end_sim();
   end
endmodule
